// ==== common/stm_regs.svh ====
// Register offsets, field positions, reset values and timing figures of the
// SMBus timeout monitor. Assumes byte offsets on a plain 8-bit register port.
`ifndef STM_REGS_SVH
`define STM_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define STM_ADDR_W          8
`define STM_DATA_W          8
`define STM_MASTER_BASE     8'h01
`define STM_SLAVE_BASE      8'h08
`define STM_TIMEOUT_BASE    8'h0E
`define STM_OFS_CTRL        8'h01
`define STM_OFS_MADDR       8'h05
`define STM_OFS_FLAGS       8'h00
`define STM_OFS_DUR         8'h01
`define STM_RESET_VAL       8'h00
`define STM_SCTRL_MASK      8'h97
`define STM_FLAGS_MASK      8'h17

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define STM_CB_IRQEN        7
`define STM_CB_MEXTEN       6
`define STM_CB_SEXTEN       5
`define STM_CB_TOUTEN       4
`define STM_FLG_SLOW        4
`define STM_FLG_MEXT        2
`define STM_FLG_SEXT        1
`define STM_FLG_MLOW        0
`define STM_CF_SSEL_HI      7
`define STM_CF_SSEL_LO      5
`define STM_CF_XSEL_HI      4
`define STM_CF_XSEL_LO      3
`define STM_CF_MSEL_HI      2
`define STM_CF_MSEL_LO      0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STM_CLK_KHZ         200000
`define STM_MS_PER_MS       1
`define STM_PRE_W           18
`define STM_MS_W            5
`define STM_MS_MAX          5'h1F
`define STM_TO_MS_0         5'h19
`define STM_TO_MS_1         5'h18
`define STM_TO_MS_2         5'h17
`define STM_TO_MS_3         5'h16
`define STM_TO_MS_4         5'h1A
`define STM_TO_MS_5         5'h1B
`define STM_TO_MS_6         5'h1C
`define STM_TO_MS_7         5'h1D
`define STM_SEXT_MS_0       5'h19
`define STM_SEXT_MS_1       5'h18
`define STM_SEXT_MS_2       5'h1A
`define STM_SEXT_MS_3       5'h1B
`define STM_MEXT_MS_0       5'h0A
`define STM_MEXT_MS_1       5'h09
`define STM_MEXT_MS_2       5'h0B
`define STM_MEXT_MS_3       5'h0C

`endif

// ==== common/stm_pkg.sv ====
// Types of the SMBus timeout monitor.
// Assumes stm_regs.svh is on the include path.
`include "stm_regs.svh"

package stm_pkg;

  typedef logic [`STM_MS_W-1:0] stm_ms_t;

  // One millisecond counter: cycle prescaler and whole milliseconds.
  typedef struct packed {
    logic [`STM_PRE_W-1:0] pre;
    stm_ms_t               ms;
  } stm_cnt_t;

  // Status handed to the protocol engine.
  typedef struct packed {
    logic slave_release;
    logic master_stop;
    logic slave_irq;
    logic master_irq;
  } stm_out_t;

  // Whole state of the monitor.
  typedef struct packed {
    logic [1:0]            scl_sync;
    logic [1:0]            sda_sync;
    logic                  scl_prev;
    logic                  sda_prev;
    logic [7:0]            master_ctrl;
    logic [7:0]            slave_ctrl;
    logic [7:0]            flags;
    logic [7:0]            dur_sel;
    stm_cnt_t              low_cnt;
    stm_cnt_t              sext_cnt;
    stm_cnt_t              mext_cnt;
    logic                  slow_fired;
    logic                  mlow_fired;
    logic                  sext_fired;
    logic                  mext_fired;
    logic                  stop_pending;
    logic [7:0]            rdata;
    stm_out_t              out;
  } stm_state_t;

endpackage : stm_pkg

// ==== logic/stm_monitor.sv ====
// SMBus layer-1 timeout monitor: clock-low and cumulative extension timers,
// sticky flags, duration selects and timeout interrupts.
// Assumes a protocol engine beside it that reports stretching, acks and
// arbitration, and acts on the release and stop pulses it emits.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "stm_regs.svh"

// Functional notes
// - Slave irq needs slave flag, enable, global enable and nonzero level.
// - With slave clock-low enable set, flag slave clock-low timeout when detected.
// - After slave clock-low timeout release both lines, await a fresh start.
// - Writing one clears the slave clock-low flag; zero leaves it.
// - Master stretch flag set on timeout; cleared by write one or address write.
// - Slave stretch flag set on timeout; cleared by write one or address write.
// - Master clock-low flag set on timeout; cleared by write one or address write.
// - Slave clock-low select: 25,24,23,22,26,27,28,29 ms.
// - Master clock-low select uses the same encoding.
// - Extension select: 25/10, 24/9, 26/11, 27/12 ms slave/master.
// - Master group at 0x01, slave group at 0x08, timeout group at 0x0E.
// - Master clock-low timeout issues a stop.
// - Arbitration loss disables the master timeout counters.
// - Extension timeout stops at once if owning data, else at byte end.
module stm_monitor
  import stm_pkg::*;
#(
  parameter int MS_CYCLES = `STM_CLK_KHZ * `STM_MS_PER_MS
)(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [`STM_ADDR_W-1:0] reg_addr,
  input  wire logic [`STM_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`STM_DATA_W-1:0] reg_rdata,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  input  wire logic                   master_active,
  input  wire logic                   arb_lost,
  input  wire logic                   master_owns_sda,
  input  wire logic                   byte_end,
  input  wire logic                   ack_seen,
  input  wire logic                   slave_ext_active,
  input  wire logic                   master_ext_active,
  input  wire logic                   global_irq_enable,
  input  wire logic [1:0]             slave_irq_level,
  input  wire logic [1:0]             master_irq_level,
  output logic                        slave_release,
  output logic                        master_stop,
  output logic                        slave_irq,
  output logic                        master_irq
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (MS_CYCLES < 1 || MS_CYCLES >= (1 << `STM_PRE_W))
  begin : g_bad_ms
    $error("MS_CYCLES does not fit the prescaler.");
  end

  localparam logic [`STM_PRE_W-1:0] PRE_LAST = `STM_PRE_W'(MS_CYCLES - 1);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic stm_cnt_t count_ms(input stm_cnt_t c);
    stm_cnt_t n;
    n = c;
    if (c.pre == PRE_LAST)
    begin
      n.pre = '0;
      if (c.ms != `STM_MS_MAX)
      begin
        n.ms = c.ms + `STM_MS_W'(1);
      end
    end
    else
    begin
      n.pre = c.pre + `STM_PRE_W'(1);
    end
    return n;
  endfunction : count_ms

  function automatic stm_ms_t low_limit(input logic [2:0] sel);
    stm_ms_t v;
    case (sel)
      3'h0:    v = `STM_TO_MS_0;
      3'h1:    v = `STM_TO_MS_1;
      3'h2:    v = `STM_TO_MS_2;
      3'h3:    v = `STM_TO_MS_3;
      3'h4:    v = `STM_TO_MS_4;
      3'h5:    v = `STM_TO_MS_5;
      3'h6:    v = `STM_TO_MS_6;
      default: v = `STM_TO_MS_7;
    endcase
    return v;
  endfunction : low_limit

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  stm_state_t st;
  stm_state_t next_st;

  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       start_cond;
  logic       stop_cond;
  logic       wr_mctrl;
  logic       wr_sctrl;
  logic       wr_maddr;
  logic       wr_flags;
  logic       wr_conf;
  logic       master_run;
  logic       slow_hit;
  logic       mlow_hit;
  logic       sext_hit;
  logic       mext_hit;
  stm_ms_t    slow_lim;
  stm_ms_t    mlow_lim;
  stm_ms_t    sext_lim;
  stm_ms_t    mext_lim;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  logic [7:0] rd_val;

  always_comb
  begin
    next_st = st;

    // ------------------------------------------------------------------------
    // Bus line sampling and start/stop detection
    // ------------------------------------------------------------------------
    next_st.scl_sync = {st.scl_sync[0], scl_in};
    next_st.sda_sync = {st.sda_sync[0], sda_in};
    scl = st.scl_sync[1];
    sda = st.sda_sync[1];
    next_st.scl_prev = scl;
    next_st.sda_prev = sda;
    scl_rise   = scl & ~st.scl_prev;
    start_cond = scl & st.scl_prev & st.sda_prev & ~sda;
    stop_cond  = scl & st.scl_prev & ~st.sda_prev & sda;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    wr_mctrl = reg_wr && reg_addr == (`STM_MASTER_BASE + `STM_OFS_CTRL);
    wr_maddr = reg_wr && reg_addr == (`STM_MASTER_BASE + `STM_OFS_MADDR);
    wr_sctrl = reg_wr && reg_addr == (`STM_SLAVE_BASE + `STM_OFS_CTRL);
    wr_flags = reg_wr && reg_addr == (`STM_TIMEOUT_BASE + `STM_OFS_FLAGS);
    wr_conf  = reg_wr && reg_addr == (`STM_TIMEOUT_BASE + `STM_OFS_DUR);

    if (wr_mctrl)
    begin
      next_st.master_ctrl = reg_wdata;
    end
    if (wr_sctrl)
    begin
      next_st.slave_ctrl = reg_wdata & `STM_SCTRL_MASK;
    end
    if (wr_conf)
    begin
      next_st.dur_sel = reg_wdata;
    end

    // ------------------------------------------------------------------------
    // Duration selects
    // ------------------------------------------------------------------------
    slow_lim = low_limit(st.dur_sel[`STM_CF_SSEL_HI:`STM_CF_SSEL_LO]);
    mlow_lim = low_limit(st.dur_sel[`STM_CF_MSEL_HI:`STM_CF_MSEL_LO]);
    case (st.dur_sel[`STM_CF_XSEL_HI:`STM_CF_XSEL_LO])
      2'h0:
      begin
        sext_lim = `STM_SEXT_MS_0;
        mext_lim = `STM_MEXT_MS_0;
      end
      2'h1:
      begin
        sext_lim = `STM_SEXT_MS_1;
        mext_lim = `STM_MEXT_MS_1;
      end
      2'h2:
      begin
        sext_lim = `STM_SEXT_MS_2;
        mext_lim = `STM_MEXT_MS_2;
      end
      default:
      begin
        sext_lim = `STM_SEXT_MS_3;
        mext_lim = `STM_MEXT_MS_3;
      end
    endcase

    // ------------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------------
    master_run = master_active & ~arb_lost;

    if (scl || scl_rise)
    begin
      next_st.low_cnt    = '0;
      next_st.slow_fired = 1'b0;
      next_st.mlow_fired = 1'b0;
    end
    else
    begin
      next_st.low_cnt = count_ms(st.low_cnt);
    end

    if (start_cond || stop_cond || !master_run)
    begin
      next_st.sext_cnt   = '0;
      next_st.sext_fired = 1'b0;
    end
    else if (slave_ext_active)
    begin
      next_st.sext_cnt = count_ms(st.sext_cnt);
    end

    if (start_cond || stop_cond || ack_seen || !master_run)
    begin
      next_st.mext_cnt   = '0;
      next_st.mext_fired = 1'b0;
    end
    else if (master_ext_active)
    begin
      next_st.mext_cnt = count_ms(st.mext_cnt);
    end

    slow_hit = st.slave_ctrl[`STM_CB_TOUTEN] && !scl && !st.slow_fired
               && st.low_cnt.ms >= slow_lim;
    mlow_hit = st.master_ctrl[`STM_CB_TOUTEN] && master_run && !scl && !st.mlow_fired
               && st.low_cnt.ms >= mlow_lim;
    sext_hit = st.master_ctrl[`STM_CB_SEXTEN] && master_run && !st.sext_fired
               && st.sext_cnt.ms >= sext_lim;
    mext_hit = st.master_ctrl[`STM_CB_MEXTEN] && master_run && !st.mext_fired
               && st.mext_cnt.ms >= mext_lim;
    if (slow_hit)
    begin
      next_st.slow_fired = 1'b1;
    end
    if (mlow_hit)
    begin
      next_st.mlow_fired = 1'b1;
    end
    if (sext_hit)
    begin
      next_st.sext_fired = 1'b1;
    end
    if (mext_hit)
    begin
      next_st.mext_fired = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Sticky flags: a set in the same cycle as a clear wins
    // ------------------------------------------------------------------------
    set_mask = '0;
    set_mask[`STM_FLG_SLOW] = slow_hit;
    set_mask[`STM_FLG_MLOW] = mlow_hit;
    set_mask[`STM_FLG_SEXT] = sext_hit;
    set_mask[`STM_FLG_MEXT] = mext_hit;
    clr_mask = '0;
    if (wr_flags)
    begin
      clr_mask = reg_wdata & `STM_FLAGS_MASK;
    end
    if (wr_maddr)
    begin
      clr_mask[`STM_FLG_MLOW] = 1'b1;
      clr_mask[`STM_FLG_SEXT] = 1'b1;
      clr_mask[`STM_FLG_MEXT] = 1'b1;
    end
    next_st.flags = ((st.flags & ~clr_mask) | set_mask) & `STM_FLAGS_MASK;

    // ------------------------------------------------------------------------
    // Actions toward the protocol engine
    // ------------------------------------------------------------------------
    next_st.out.slave_release = slow_hit;
    next_st.out.master_stop   = mlow_hit;
    if (sext_hit || mext_hit)
    begin
      if (master_owns_sda)
      begin
        next_st.out.master_stop = 1'b1;
      end
      else
      begin
        next_st.stop_pending = 1'b1;
      end
    end
    if (st.stop_pending && (byte_end || !master_run))
    begin
      next_st.stop_pending    = 1'b0;
      next_st.out.master_stop = master_run;
    end

    next_st.out.slave_irq = next_st.flags[`STM_FLG_SLOW] && next_st.slave_ctrl[`STM_CB_IRQEN]
                            && global_irq_enable && slave_irq_level != 2'h0;
    next_st.out.master_irq = (next_st.flags[`STM_FLG_MLOW] || next_st.flags[`STM_FLG_SEXT]
                              || next_st.flags[`STM_FLG_MEXT])
                             && next_st.master_ctrl[`STM_CB_IRQEN]
                             && global_irq_enable && master_irq_level != 2'h0;

    // ------------------------------------------------------------------------
    // Read data, valid only in the cycle after the strobe
    // ------------------------------------------------------------------------
    rd_val = '0;
    case (reg_addr)
      `STM_MASTER_BASE + `STM_OFS_CTRL:     rd_val = st.master_ctrl;
      `STM_SLAVE_BASE + `STM_OFS_CTRL:      rd_val = st.slave_ctrl;
      `STM_TIMEOUT_BASE + `STM_OFS_FLAGS:   rd_val = st.flags;
      `STM_TIMEOUT_BASE + `STM_OFS_DUR:     rd_val = st.dur_sel;
      default:                              rd_val = '0;
    endcase
    next_st.rdata = reg_rd ? rd_val : '0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata     = st.rdata;
  assign slave_release = st.out.slave_release;
  assign master_stop   = st.out.master_stop;
  assign slave_irq     = st.out.slave_irq;
  assign master_irq    = st.out.master_irq;

endmodule : stm_monitor

`default_nettype wire

// ==== dv/stm_bus_model.sv ====
// Far-side bus model: other masters and slaves moving the clock and data lines.
// Assumes the bench raises frame for a transaction and hold_low to pin the clock.
`timescale 1ns/100ps
`default_nettype none
module stm_bus_model (
  input  wire logic frame,
  input  wire logic hold_low,
  output logic      scl,
  output logic      sda
);
  // ---------------------------------------------------------------------------
  // Line sequencer, one step every 40 ns
  // ---------------------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    #1.3;
    forever
    begin
      #40;
      if (hold_low)
        scl = 1'b0;
      else if (frame && scl && sda)
        sda = 1'b0;
      else if (frame)
        scl = ~scl;
      else if (scl && !sda)
        sda = 1'b1;
      else if (!scl && sda)
        sda = 1'b0;
      else if (!scl)
        scl = 1'b1;
    end
  end
endmodule : stm_bus_model
`default_nettype wire

// ==== dv/stm_monitor_sva.sv ====
// Checker for the timeout monitor ports.
// Assumes it is bound into every instance of the monitor.
`timescale 1ns/100ps
`default_nettype none
module stm_monitor_sva
  import stm_pkg::*;
#(
  parameter int MS_CYCLES = 200000
)(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       scl_in,
  input wire logic       master_active,
  input wire logic       global_irq_enable,
  input wire logic [1:0] slave_irq_level,
  input wire logic [1:0] master_irq_level,
  input wire logic       slave_release,
  input wire logic       master_stop,
  input wire logic       slave_irq,
  input wire logic       master_irq
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  localparam int MIN_LOW = 22 * MS_CYCLES;
  logic [31:0] low_run;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      low_run <= 32'h0;
    else if (scl_in)
      low_run <= 32'h0;
    else
      low_run <= low_run + 32'h1;
  end
  a_slave_irq_gate: assert property (slave_irq |->
    $past(global_irq_enable) && $past(slave_irq_level) != 2'h0) else $error("slave irq ungated");
  a_master_irq_gate: assert property (master_irq |->
    $past(global_irq_enable) && $past(master_irq_level) != 2'h0) else $error("master irq ungated");
  a_irq_gie_off: assert property (!global_irq_enable |=> !slave_irq && !master_irq)
    else $error("irq without global enable");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_release_once: assert property (slave_release |=> !slave_release [*2])
    else $error("release pulse too long");
  a_stop_once: assert property (master_stop |=> !master_stop)
    else $error("stop pulse too long");
  a_release_late: assert property (slave_release |-> low_run >= MIN_LOW)
    else $error("release before clock low limit");
  a_stop_master: assert property (master_stop |-> $past(master_active))
    else $error("stop without active master");
endmodule : stm_monitor_sva
bind stm_monitor stm_monitor_sva #(.MS_CYCLES(MS_CYCLES)) stm_monitor_sva_inst (
  .clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .master_active(master_active), .global_irq_enable(global_irq_enable),
  .slave_irq_level(slave_irq_level), .master_irq_level(master_irq_level),
  .slave_release(slave_release), .master_stop(master_stop), .slave_irq(slave_irq),
  .master_irq(master_irq));
`default_nettype wire

// ==== dv/stm_monitor_tb.sv ====
// Self-checking bench for the timeout monitor.
// Assumes the bus model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module stm_monitor_tb
  import stm_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------------------
  localparam int MS = 20;
  logic clk_sys, rst, reg_wr, reg_rd, scl_in, sda_in, master_active, arb_lost, byte_end;
  logic master_owns_sda, ack_seen, slave_ext_active, master_ext_active, global_irq_enable;
  logic slave_release, master_stop, slave_irq, master_irq, frame, hold_low;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0] slave_irq_level, master_irq_level;
  logic [7:0] regs [4] = '{8'h0E, 8'h02, 8'h09, 8'h0F};
  int         lows [8] = '{25, 24, 23, 22, 26, 27, 28, 29};
  int         err_total, num_checks, cycles, n;
  stm_monitor #(.MS_CYCLES(MS)) stm_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl_in), .sda_in(sda_in), .master_active(master_active),
    .arb_lost(arb_lost), .master_owns_sda(master_owns_sda), .byte_end(byte_end),
    .ack_seen(ack_seen), .slave_ext_active(slave_ext_active),
    .master_ext_active(master_ext_active), .global_irq_enable(global_irq_enable),
    .slave_irq_level(slave_irq_level), .master_irq_level(master_irq_level),
    .slave_release(slave_release), .master_stop(master_stop), .slave_irq(slave_irq),
    .master_irq(master_irq));
  stm_bus_model stm_bus_model_inst (.frame(frame), .hold_low(hold_low), .scl(scl_in),
    .sda(sda_in));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask : wr
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    rv = reg_rdata;
    check("reg", rv, exp);
    tick();
  endtask : rchk
  task wait_evt(input logic sel, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && !(sel ? master_stop : slave_release))
    begin
      tick();
      cnt++;
    end
  endtask : wait_evt
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    {reg_wr, reg_rd, master_active, arb_lost, byte_end, master_owns_sda} = 6'h00;
    {ack_seen, slave_ext_active, master_ext_active, global_irq_enable} = 4'h0;
    {frame, hold_low, slave_irq_level, master_irq_level} = 6'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    rst <= 1'b0;
    tick();
    for (int i = 0; i < 4; i++)
      rchk(regs[i], 8'h00);
    rchk(8'h20, 8'h00);
    wr(8'h09, 8'hFF);
    rchk(8'h09, 8'h97);
    wr(8'h0F, 8'hFF);
    rchk(8'h0F, 8'hFF);
    wr(8'h02, 8'h0F);
    rchk(8'h02, 8'h0F);
    $display("registers done");
    wr(8'h09, 8'h90);
    global_irq_enable <= 1'b1;
    slave_irq_level <= 2'h1;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h0F, {c[2:0], 5'h00});
      hold_low <= 1'b1;
      wait_evt(1'b0, 700, n);
      check("slave_time", 8'(n >= lows[c] * MS && n <= lows[c] * MS + 14), 8'h01);
      rchk(8'h0E, 8'h10);
      check("slave_irq", {7'h00, slave_irq}, 8'h01);
      wr(8'h0E, 8'h00);
      rchk(8'h0E, 8'h10);
      wr(8'h0E, 8'h10);
      rchk(8'h0E, 8'h00);
      hold_low <= 1'b0;
      repeat (30) tick();
    end
    $display("slave clock low done");
    wr(8'h09, 8'h00);
    wr(8'h02, 8'h90);
    wr(8'h0F, 8'h03);
    master_active <= 1'b1;
    hold_low <= 1'b1;
    wait_evt(1'b1, 700, n);
    check("master_time", 8'(n >= 22 * MS && n <= 22 * MS + 14), 8'h01);
    rchk(8'h0E, 8'h01);
    check("master_irq", {7'h00, master_irq}, 8'h00);
    master_irq_level <= 2'h1;
    repeat (2) tick();
    check("master_irq", {7'h00, master_irq}, 8'h01);
    wr(8'h06, 8'h00);
    rchk(8'h0E, 8'h00);
    hold_low <= 1'b0;
    repeat (30) tick();
    arb_lost <= 1'b1;
    hold_low <= 1'b1;
    wait_evt(1'b1, 700, n);
    check("arb_quiet", 8'(n == 700), 8'h01);
    rchk(8'h0E, 8'h00);
    hold_low <= 1'b0;
    repeat (30) tick();
    arb_lost <= 1'b0;
    repeat (2) tick();
    $display("master clock low done");
    wr(8'h0F, 8'h08);
    wr(8'h02, 8'hC0);
    frame <= 1'b1;
    repeat (30) tick();
    master_owns_sda <= 1'b1;
    master_ext_active <= 1'b1;
    repeat (100) tick();
    ack_seen <= 1'b1;
    tick();
    ack_seen <= 1'b0;
    wait_evt(1'b1, 300, n);
    check("mext_time", 8'(n >= 9 * MS && n <= 9 * MS + 10), 8'h01);
    rchk(8'h0E, 8'h04);
    master_ext_active <= 1'b0;
    wr(8'h0E, 8'h04);
    rchk(8'h0E, 8'h00);
    frame <= 1'b0;
    repeat (60) tick();
    frame <= 1'b1;
    repeat (30) tick();
    wr(8'h02, 8'hA0);
    master_owns_sda <= 1'b0;
    slave_ext_active <= 1'b1;
    wait_evt(1'b1, 600, n);
    check("held_stop", 8'(n == 600), 8'h01);
    rchk(8'h0E, 8'h02);
    byte_end <= 1'b1;
    tick();
    byte_end <= 1'b0;
    wait_evt(1'b1, 4, n);
    check("byte_stop", 8'(n < 4), 8'h01);
    slave_ext_active <= 1'b0;
    wr(8'h06, 8'h00);
    rchk(8'h0E, 8'h00);
    frame <= 1'b0;
    repeat (20) tick();
    $display("stretch done");
    wrap_up();
  end
endmodule : stm_monitor_tb
`default_nettype wire
